// [hw/camio_defs.svh]
//
// Behaviour
// - Untriggered input line serves as user input
// - Input levels readable only as status word
// - Per-input polarity flip, true inverts
// - Each output selects one of five sources
// - Trigger-wait source only in standard mode
// - Reset: out1 exposure active, out2 ready
// - User source drives written level
// - Word's low four bits set user outputs
// - User level applied before output inverter
// - Per-output polarity flip after source mux
// - Timer waits delay low, then goes high
// - Timer low again after duration elapses
// - Only exposure start may start timers
// - Timer N reaches output line N only
// - Inverted timer line: high during delay
// - At most one input gets hardware trigger
// - Delay is raw 0-4095 times base
// - Duration is raw 1-4095 times base
`ifndef CAMIO_DEFS_SVH
`define CAMIO_DEFS_SVH

// ========================================
// Register byte addresses
`define CAMIO_A_CTRL      8'h00
`define CAMIO_A_IN_INV    8'h04
`define CAMIO_A_STATUS    8'h08
`define CAMIO_A_OUT_SRC   8'h0C
`define CAMIO_A_OUT_INV   8'h10
`define CAMIO_A_USER_ALL  8'h14
`define CAMIO_A_USER_SEL  8'h18
`define CAMIO_A_USER_VAL  8'h1C
`define CAMIO_A_TMR_SEL   8'h20
`define CAMIO_A_TMR_DLY   8'h24
`define CAMIO_A_TMR_DUR   8'h28
`define CAMIO_A_DLY_BASE  8'h2C
`define CAMIO_A_DUR_BASE  8'h30
`define CAMIO_A_TMR_TRIG  8'h34

// ========================================
// Field positions
`define CAMIO_F_STD       0
`define CAMIO_F_TSEL_LO   1
`define CAMIO_F_OST_LO    2

// ========================================
// Reset values
`define CAMIO_R_STD       1'h1
`define CAMIO_R_TSEL      2'h1
`define CAMIO_R_SRC       12'h90A
`define CAMIO_R_DLY_RAW   12'h000
`define CAMIO_R_DUR_RAW   12'h001
`define CAMIO_R_BASE      12'h001

// ========================================
// Timing
`define CAMIO_CLK_NS      100
`define CAMIO_US_NS       1000
`define CAMIO_CYC_PER_US  (`CAMIO_US_NS / `CAMIO_CLK_NS)

`endif

// [hw/camio_pkg.sv]
package camio_pkg;

  // ========================================
  // Output line source codes
  typedef enum logic [2:0] {
    SRC_ATW,
    SRC_TRDY,
    SRC_EXPO,
    SRC_TIMER,
    SRC_USER
  } camio_src_t;

  // Timer phases
  typedef enum logic [1:0] {
    T_IDLE,
    T_DELAY,
    T_PULSE
  } camio_tph_t;

  // Wishbone request from master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } camio_wb_req_t;

  // Timer state
  typedef struct packed {
    camio_tph_t  st;
    logic [31:0] cnt;
    logic [31:0] dly;
    logic [31:0] dur;
    logic        out;
  } camio_tmr_st_t;

  // Top-level state
  typedef struct packed {
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic             exp_q;
    logic             std_mode;
    logic [1:0]       trig_sel;
    logic [1:0]       in_inv;
    logic [11:0]      src;
    logic [3:0]       out_inv;
    logic [3:0]       user;
    logic [1:0]       user_sel;
    logic [1:0]       tmr_sel;
    logic [3:0]       tmr_en;
    logic [3:0][11:0] dly_raw;
    logic [3:0][11:0] dur_raw;
    logic [11:0]      dly_base;
    logic [11:0]      dur_base;
    logic             ack;
    logic [31:0]      rdat;
    logic [3:0]       out;
    logic             trig;
    logic [1:0]       uin;
  } camio_st_t;

endpackage

// [hw/camio_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "camio_defs.svh"

module camio_timer #(
  parameter int unsigned RAW_W  = 12,
  parameter int unsigned BASE_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic [RAW_W-1:0]  dly_raw_i,
  input  wire logic [BASE_W-1:0] dly_base_i,
  input  wire logic [RAW_W-1:0]  dur_raw_i,
  input  wire logic [BASE_W-1:0] dur_base_i,
  output logic                   tmr_o
);
  import camio_pkg::*;

  camio_tmr_st_t s_q;   // Registered state
  camio_tmr_st_t s_d;   // Next state
  logic [31:0]   dly_c; // Delay in cycles
  logic [31:0]   dur_c; // Duration in cycles

  // ========================================
  // Raw count times base times cycles per us
  assign dly_c = 32'(dly_raw_i) * 32'(dly_base_i) * 32'(`CAMIO_CYC_PER_US);
  assign dur_c = 32'(dur_raw_i) * 32'(dur_base_i) * 32'(`CAMIO_CYC_PER_US);

  // Phase sequencing; retrigger while busy ignored
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      T_IDLE: begin
        if (start_i) begin
          s_d.dly = dly_c;
          s_d.dur = dur_c;
          s_d.cnt = '0;
          if (dly_c == 32'h0) begin
            s_d.st  = T_PULSE;
            s_d.out = 1'b1;
          end else begin
            s_d.st = T_DELAY;
          end
        end
      end
      T_DELAY: begin
        if (s_q.cnt == s_q.dly - 32'h1) begin
          s_d.st  = T_PULSE;
          s_d.out = 1'b1;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      T_PULSE: begin
        if (s_q.cnt == s_q.dur - 32'h1) begin
          s_d.st  = T_IDLE;
          s_d.out = 1'b0;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{st: T_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tmr_o = s_q.out;

  // ========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_delay_low: assert property (s_q.st == T_DELAY |-> !s_q.out)
    else $error("timer high during delay");
  a_delay_len: assert property ($rose(s_q.out) && $past(s_q.st == T_DELAY)
    |-> $past(s_q.cnt) == $past(s_q.dly) - 32'h1)
    else $error("timer delay length wrong");
  a_pulse_end: assert property ($fell(s_q.out)
    |-> $past(s_q.cnt) == $past(s_q.dur) - 32'h1 && s_q.st == T_IDLE)
    else $error("timer duration length wrong");
  a_start_src: assert property ($past(s_q.st == T_IDLE) && s_q.st != T_IDLE
    |-> $past(start_i))
    else $error("timer left idle without start");

  c_timer_pulse: cover property ($rose(s_q.out) ##[1:50] $fell(s_q.out));

endmodule
`default_nettype wire

// [hw/camio_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "camio_defs.svh"

module camio_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire camio_pkg::camio_wb_req_t wb_req_i,
  output logic                          wb_ack_o,
  output logic [31:0]                   wb_dat_o,
  input  wire logic [1:0]               line_in_i,
  input  wire logic                     exposure_active_i,
  input  wire logic                     trigger_ready_i,
  input  wire logic                     acq_trigger_wait_i,
  output logic [3:0]                    out_line_o,
  output logic                          external_hw_trigger_o,
  output logic [1:0]                    user_input_o
);
  import camio_pkg::*;

  // ========================================
  // Declarations
  camio_st_t   s_q;       // Registered state
  camio_st_t   s_d;       // Next state
  logic [1:0]  lvl;       // Input levels after inverter
  logic [1:0]  asg;       // Line given to hw trigger
  logic [3:0]  tmr;       // Timer outputs
  logic [3:0]  raw_src;   // Selected source per line
  logic        req;       // New bus request
  logic        exp_start; // Exposure start edge

  // Byte-lane merge of a write
  function automatic logic [31:0] wmerge(
    input logic [31:0] o,
    input logic [31:0] d,
    input logic [3:0]  b
  );
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  // ========================================
  // Input path
  // Polarity flip on synchronised pins
  assign lvl = s_q.sync2 ^ s_q.in_inv;

  // One-hot mask of trigger line, never both
  always_comb begin
    asg = 2'b00;
    if (s_q.trig_sel == 2'h1) begin
      asg = 2'b01;
    end else if (s_q.trig_sel == 2'h2) begin
      asg = 2'b10;
    end
  end

  assign exp_start = exposure_active_i & ~s_q.exp_q;
  assign req       = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;

  // ========================================
  // Timers, one per output line
  for (genvar g = 0; g < 4; g++) begin : g_tmr
    camio_timer #(
      .RAW_W  (12),
      .BASE_W (12)
    ) u_tmr (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .start_i    (exp_start & s_q.tmr_en[g]),
      .dly_raw_i  (s_q.dly_raw[g]),
      .dly_base_i (s_q.dly_base),
      .dur_raw_i  (s_q.dur_raw[g]),
      .dur_base_i (s_q.dur_base),
      .tmr_o      (tmr[g])
    );
  end

  // ========================================
  // Output source mux, before inverter
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (s_q.src[3*i +: 3])
        3'(SRC_ATW): raw_src[i] = acq_trigger_wait_i & s_q.std_mode;
        3'(SRC_TRDY): raw_src[i] = trigger_ready_i;
        3'(SRC_EXPO): raw_src[i] = exposure_active_i;
        3'(SRC_TIMER): raw_src[i] = tmr[i];
        3'(SRC_USER): raw_src[i] = s_q.user[i];
        default: raw_src[i] = 1'b0;
      endcase
    end
  end

  // ========================================
  // Next-state logic: pins, bus, registers
  always_comb begin
    logic [31:0] w; // Merged write word
    logic [2:0]  f; // One source field
    w = '0;
    f = '0;
    s_d = s_q;
    // Two-flop pin synchroniser
    s_d.sync1 = line_in_i;
    s_d.sync2 = s_q.sync1;
    s_d.exp_q = exposure_active_i;
    // Registered line outputs
    s_d.out  = raw_src ^ s_q.out_inv;
    s_d.trig = |(lvl & asg);
    s_d.uin  = lvl & ~asg;
    // One-cycle ack per request
    s_d.ack = req;
    // Register writes
    if (req && wb_req_i.we) begin
      case (wb_req_i.adr & 8'hFC)
        `CAMIO_A_CTRL: begin
          w = wmerge({29'h0, s_q.trig_sel, s_q.std_mode}, wb_req_i.dat, wb_req_i.sel);
          s_d.std_mode = w[`CAMIO_F_STD];
          // Code 3 would name no line; keep old
          if (w[`CAMIO_F_TSEL_LO +: 2] != 2'h3) begin
            s_d.trig_sel = w[`CAMIO_F_TSEL_LO +: 2];
          end
        end
        `CAMIO_A_IN_INV: begin
          w = wmerge({30'h0, s_q.in_inv}, wb_req_i.dat, wb_req_i.sel);
          s_d.in_inv = w[1:0];
        end
        `CAMIO_A_OUT_SRC: begin
          w = wmerge({20'h0, s_q.src}, wb_req_i.dat, wb_req_i.sel);
          // Field kept if code illegal or ATW in legacy
          for (int i = 0; i < 4; i++) begin
            f = w[3*i +: 3];
            if (f <= 3'(SRC_USER) && !(f == 3'(SRC_ATW) && !s_q.std_mode)) begin
              s_d.src[3*i +: 3] = f;
            end
          end
        end
        `CAMIO_A_OUT_INV: begin
          w = wmerge({28'h0, s_q.out_inv}, wb_req_i.dat, wb_req_i.sel);
          s_d.out_inv = w[3:0];
        end
        `CAMIO_A_USER_ALL: begin
          w = wmerge({28'h0, s_q.user}, wb_req_i.dat, wb_req_i.sel);
          s_d.user = w[3:0];
        end
        `CAMIO_A_USER_SEL: begin
          w = wmerge({30'h0, s_q.user_sel}, wb_req_i.dat, wb_req_i.sel);
          s_d.user_sel = w[1:0];
        end
        `CAMIO_A_USER_VAL: begin
          // Single output selected by user_sel
          if (wb_req_i.sel[0]) begin
            s_d.user[s_q.user_sel] = wb_req_i.dat[0];
          end
        end
        `CAMIO_A_TMR_SEL: begin
          w = wmerge({30'h0, s_q.tmr_sel}, wb_req_i.dat, wb_req_i.sel);
          s_d.tmr_sel = w[1:0];
        end
        `CAMIO_A_TMR_DLY: begin
          w = wmerge({20'h0, s_q.dly_raw[s_q.tmr_sel]}, wb_req_i.dat, wb_req_i.sel);
          s_d.dly_raw[s_q.tmr_sel] = w[11:0];
        end
        `CAMIO_A_TMR_DUR: begin
          w = wmerge({20'h0, s_q.dur_raw[s_q.tmr_sel]}, wb_req_i.dat, wb_req_i.sel);
          // Zero duration not allowed; ignored
          if (w[11:0] != 12'h000) begin
            s_d.dur_raw[s_q.tmr_sel] = w[11:0];
          end
        end
        `CAMIO_A_DLY_BASE: begin
          w = wmerge({20'h0, s_q.dly_base}, wb_req_i.dat, wb_req_i.sel);
          // Base at least one microsecond
          if (w[11:0] != 12'h000) begin
            s_d.dly_base = w[11:0];
          end
        end
        `CAMIO_A_DUR_BASE: begin
          w = wmerge({20'h0, s_q.dur_base}, wb_req_i.dat, wb_req_i.sel);
          if (w[11:0] != 12'h000) begin
            s_d.dur_base = w[11:0];
          end
        end
        `CAMIO_A_TMR_TRIG: begin
          w = wmerge({28'h0, s_q.tmr_en}, wb_req_i.dat, wb_req_i.sel);
          s_d.tmr_en = w[3:0];
        end
        default: begin
          // Unmapped or read-only: ignored
          w = '0;
        end
      endcase
    end
    // Register reads, captured with ack
    if (req && !wb_req_i.we) begin
      case (wb_req_i.adr & 8'hFC)
        `CAMIO_A_CTRL: s_d.rdat = {29'h0, s_q.trig_sel, s_q.std_mode};
        `CAMIO_A_IN_INV: s_d.rdat = {30'h0, s_q.in_inv};
        `CAMIO_A_STATUS: s_d.rdat = {26'h0, s_q.out, lvl};
        `CAMIO_A_OUT_SRC: s_d.rdat = {20'h0, s_q.src};
        `CAMIO_A_OUT_INV: s_d.rdat = {28'h0, s_q.out_inv};
        `CAMIO_A_USER_ALL: s_d.rdat = {28'h0, s_q.user};
        `CAMIO_A_USER_SEL: s_d.rdat = {30'h0, s_q.user_sel};
        `CAMIO_A_USER_VAL: s_d.rdat = {31'h0, s_q.user[s_q.user_sel]};
        `CAMIO_A_TMR_SEL: s_d.rdat = {30'h0, s_q.tmr_sel};
        `CAMIO_A_TMR_DLY: s_d.rdat = {20'h0, s_q.dly_raw[s_q.tmr_sel]};
        `CAMIO_A_TMR_DUR: s_d.rdat = {20'h0, s_q.dur_raw[s_q.tmr_sel]};
        `CAMIO_A_DLY_BASE: s_d.rdat = {20'h0, s_q.dly_base};
        `CAMIO_A_DUR_BASE: s_d.rdat = {20'h0, s_q.dur_base};
        `CAMIO_A_TMR_TRIG: s_d.rdat = {28'h0, s_q.tmr_en};
        default: s_d.rdat = 32'h0;
      endcase
    end
  end

  // ========================================
  // State register with reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.std_mode <= `CAMIO_R_STD;
      s_q.trig_sel <= `CAMIO_R_TSEL;
      s_q.src      <= `CAMIO_R_SRC;
      s_q.dly_raw  <= {4{`CAMIO_R_DLY_RAW}};
      s_q.dur_raw  <= {4{`CAMIO_R_DUR_RAW}};
      s_q.dly_base <= `CAMIO_R_BASE;
      s_q.dur_base <= `CAMIO_R_BASE;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================
  // Outputs from flops
  assign wb_ack_o              = s_q.ack;
  assign wb_dat_o              = s_q.rdat;
  assign out_line_o            = s_q.out;
  assign external_hw_trigger_o = s_q.trig;
  assign user_input_o          = s_q.uin;

  // ========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  a_trig_excl: assert property (!(|(user_input_o & $past(asg))))
    else $error("trigger line also user input");
  a_trig_onehot: assert property ($onehot0(asg))
    else $error("two lines assigned to trigger");
  a_in_status: assert property (wb_ack_o && $past(!wb_req_i.we && (wb_req_i.adr & 8'hFC) == `CAMIO_A_STATUS)
    |-> wb_dat_o[1:0] == ($past(s_q.sync2) ^ $past(s_q.in_inv)))
    else $error("input status readback wrong");
  a_reset_src: assert property ($fell(rst_i)
    |-> s_q.src[2:0] == 3'(SRC_EXPO) && s_q.src[5:3] == 3'(SRC_TRDY))
    else $error("reset sources wrong");
  a_expo_route: assert property ($past(s_q.src[2:0] == 3'(SRC_EXPO))
    |-> out_line_o[0] == ($past(exposure_active_i) ^ $past(s_q.out_inv[0])))
    else $error("exposure source not on line 1");
  a_atw_legacy: assert property ($past(!s_q.std_mode && s_q.src[5:3] == 3'(SRC_ATW))
    |-> out_line_o[1] == $past(s_q.out_inv[1]))
    else $error("trigger wait passed in legacy mode");
  a_user_pin: assert property ($past(s_q.src[8:6] == 3'(SRC_USER))
    |-> out_line_o[2] == ($past(s_q.user[2]) ^ $past(s_q.out_inv[2])))
    else $error("user level not ahead of inverter");
  a_timer_route: assert property ($past(s_q.src[11:9] == 3'(SRC_TIMER))
    |-> out_line_o[3] == ($past(tmr[3]) ^ $past(s_q.out_inv[3])))
    else $error("timer 4 not on line 4");
  a_user_read: assert property (wb_ack_o && $past(!wb_req_i.we && (wb_req_i.adr & 8'hFC) == `CAMIO_A_USER_ALL)
    |-> wb_dat_o == {28'h0, $past(s_q.user)})
    else $error("user word readback wrong");

  c_user_write: cover property (req && wb_req_i.we && (wb_req_i.adr & 8'hFC) == `CAMIO_A_USER_ALL);
  c_timer_line: cover property (s_q.src[2:0] == 3'(SRC_TIMER) && $rose(out_line_o[0]));
  c_hw_trig: cover property ($rose(external_hw_trigger_o));

endmodule
`default_nettype wire

// [verification/camio_ext_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ========================================
// External equipment on the camera lines
module camio_ext_model (
  input  wire logic [1:0] lines_i,   // Wanted input pin levels
  input  wire logic [2:0] sigs_i,    // Wanted {wait, ready, exposure}
  output logic      [1:0] line_in_o, // Opto input pins
  output logic            expo_o,    // Exposure active level
  output logic            trdy_o,    // Trigger ready level
  output logic            atw_o      // Trigger wait level
);
  // Levels follow the bench, which changes them just after an edge
  assign line_in_o = lines_i;
  assign expo_o    = sigs_i[0];
  assign trdy_o    = sigs_i[1];
  assign atw_o     = sigs_i[2];
endmodule

`default_nettype wire

// [verification/camio_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "camio_defs.svh"

// ========================================
// Bench for the camera line block
module camio_top_tb;
  import camio_pkg::*;
  logic          clk_i;    // 10 MHz clock
  logic          rst_i;    // Sync reset
  camio_wb_req_t req;      // Bus request
  logic          wb_ack;   // Bus answer
  logic [31:0]   wb_dat;   // Read data
  logic [1:0]    lines;    // Wanted pin levels
  logic [2:0]    sigs;     // Wanted camera signals
  logic [1:0]    line_in;  // Input pins
  logic          expo;     // Exposure active
  logic          trdy;     // Trigger ready
  logic          atw;      // Trigger wait
  logic [3:0]    out_line; // Output lines
  logic          ext_trig; // Trigger line level
  logic [1:0]    uin;      // User input levels
  int            failures; // Mismatch count
  int            n_tests;  // Compare count
  logic [31:0]   seed;     // Xorshift state
  logic [31:0]   rd;       // Last read word
  int            m_std;    // Model: standard mode
  int            m_src[4]; // Model: source codes
  logic [3:0]    m_inv;    // Model: output inverts
  logic [3:0]    m_user;   // Model: user levels

  camio_ext_model ext (.lines_i(lines), .sigs_i(sigs), .line_in_o(line_in), .expo_o(expo), .trdy_o(trdy),
                       .atw_o(atw));
  camio_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat),
                 .line_in_i(line_in), .exposure_active_i(expo), .trigger_ready_i(trdy),
                 .acq_trigger_wait_i(atw), .out_line_o(out_line), .external_hw_trigger_o(ext_trig),
                 .user_input_o(uin));

  // Clock generator
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Pseudo-random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected output lines from the model
  function automatic logic [3:0] exp_out();
    logic [3:0] r;
    logic       b;
    for (int i = 0; i < 4; i++) begin
      case (m_src[i])
        0: b = (m_std != 0) & atw;
        1: b = trdy;
        2: b = expo;
        4: b = m_user[i];
        default: b = 1'b0; // Idle timer
      endcase
      r[i] = b ^ m_inv[i];
    end
    return r;
  endfunction

  // Verdict and end of run
  task automatic final_report();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      failures++;
      final_report();
    end
    rd = wb_dat;
    req <= '0;
  endtask

  // Read and compare masked bits
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h00000000);
    chk(nm, e & m, rd & m);
  endtask

  // Let outputs settle, then compare lines
  task automatic line_chk();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("out_line", exp_out(), out_line);
  endtask

  // One timer run on its own line, all lines timer sourced
  task automatic run_timer(input int n, input int dly, input int dur, input int db, input int ub, input int inv);
    int         k;
    int         w;
    logic [3:0] im;
    logic [3:0] oth;
    im  = (inv != 0) ? 4'hF : 4'h0;
    oth = 4'h0;
    wb(1'b1, `CAMIO_A_TMR_SEL, n);
    wb(1'b1, `CAMIO_A_TMR_DLY, dly);
    wb(1'b1, `CAMIO_A_TMR_DUR, dur);
    wb(1'b1, `CAMIO_A_DLY_BASE, db);
    wb(1'b1, `CAMIO_A_DUR_BASE, ub);
    wb(1'b1, `CAMIO_A_OUT_SRC, 32'h000006DB);
    wb(1'b1, `CAMIO_A_OUT_INV, {28'h0000000, im});
    wb(1'b1, `CAMIO_A_TMR_TRIG, 32'h00000001 << n);
    // Exposure low first so the next rise is a real start
    sigs <= 3'h0;
    // Model follows: every line timer sourced, shared invert
    m_src = '{3, 3, 3, 3};
    m_inv = im;
    line_chk();
    chk("timer_idle", im, out_line);
    @(posedge clk_i);
    sigs <= 3'h1;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
      oth |= out_line ^ im;
    end while (out_line[n] === im[n] && k < 100000);
    chk("timer_delay", dly * db * `CAMIO_CYC_PER_US + 3, k);
    w = 0;
    while (out_line[n] !== im[n] && w < 100000) begin
      @(negedge clk_i);
      w++;
      oth |= out_line ^ im;
    end
    chk("timer_width", dur * ub * `CAMIO_CYC_PER_US, w);
    chk("timer_other", 4'h0, oth & ~(4'h1 << n));
    @(posedge clk_i);
    sigs <= 3'h0;
  endtask

  // Watchdog sized well above the expected run of about a thousand cycles
  initial begin
    #(100 * 60000);
    failures++;
    final_report();
  end

  // Main sequence
  initial begin
    int         s;
    int         ts;
    logic [1:0] iv;
    logic [1:0] lv;
    logic [1:0] um;
    logic [31:0] v;
    req = '0;
    lines = 2'h0;
    sigs = 3'h0;
    rst_i = 1'b1;
    failures = 0;
    n_tests = 0;
    seed = 32'h00007B64;
    m_std = 1;
    m_src = '{2, 1, 4, 4};
    m_inv = 4'h0;
    m_user = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    rdc("ctrl", `CAMIO_A_CTRL, 32'h00000003, 32'hFFFFFFFF);
    rdc("out_src", `CAMIO_A_OUT_SRC, 32'h0000090A, 32'hFFFFFFFF);
    rdc("user_all", `CAMIO_A_USER_ALL, 32'h00000000, 32'hFFFFFFFF);
    wb(1'b1, 8'h3C, rnd());
    rdc("unmapped", 8'h3C, 32'h00000000, 32'hFFFFFFFF);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      sigs <= {1'b0, k[1:0]};
      line_chk();
    end
    // Random sources, inverts, user levels and mode
    for (int it = 0; it < 16; it++) begin
      for (int i = 0; i < 4; i++) begin
        m_src[i] = rnd() % 5;
      end
      m_inv = 4'(rnd());
      v = 32'(m_src[0]) | (32'(m_src[1]) << 3) | (32'(m_src[2]) << 6) | (32'(m_src[3]) << 9);
      wb(1'b1, `CAMIO_A_CTRL, 32'h00000003);
      m_std = 1;
      wb(1'b1, `CAMIO_A_OUT_SRC, v);
      wb(1'b1, `CAMIO_A_OUT_INV, {28'h0000000, m_inv});
      v = rnd();
      wb(1'b1, `CAMIO_A_USER_ALL, v);
      m_user = v[3:0];
      s = rnd() % 4;
      v = rnd() & 32'h00000001;
      wb(1'b1, `CAMIO_A_USER_SEL, s);
      wb(1'b1, `CAMIO_A_USER_VAL, v);
      m_user[s] = v[0];
      rdc("user_val", `CAMIO_A_USER_VAL, v, 32'h00000001);
      rdc("user_all", `CAMIO_A_USER_ALL, {28'h0000000, m_user}, 32'h0000000F);
      if (rnd() & 32'h00000001) begin
        wb(1'b1, `CAMIO_A_CTRL, 32'h00000002);
        m_std = 0;
      end
      @(posedge clk_i);
      sigs <= 3'(rnd());
      line_chk();
    end
    // Input inverts and trigger line choice
    for (int it = 0; it < 12; it++) begin
      iv = 2'(rnd());
      ts = rnd() % 3;
      wb(1'b1, `CAMIO_A_IN_INV, {30'h00000000, iv});
      wb(1'b1, `CAMIO_A_CTRL, (ts << 1) | 1);
      @(posedge clk_i);
      lines <= 2'(rnd());
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      lv = lines ^ iv;
      um = (ts == 0) ? 2'h0 : 2'(1 << (ts - 1));
      chk("ext_trig", (ts == 0) ? 1'b0 : lv[ts-1], ext_trig);
      chk("user_in", lv & ~um, uin);
      rdc("status", `CAMIO_A_STATUS, {30'h00000000, lv}, 32'h00000003);
    end
    // Each timer on its own line, plain and inverted
    run_timer(0, 2, 3, 1, 1, 0);
    run_timer(1, 1, 2, 2, 1, 0);
    run_timer(2, 3, 1, 1, 2, 1);
    run_timer(3, 1, 1, 1, 1, 1);
    final_report();
  end
endmodule

`default_nettype wire
